// *** include/cssq_pkg.sv ***
package cssq_pkg;
	localparam int          CLK_MHZ         = 100;
	localparam int          DWELL_BASE_US   = 62500;
	localparam int          DWELL_BASE_CYC  = DWELL_BASE_US * CLK_MHZ;
	localparam logic [3:0]  DWELL_SEL_MAX   = 4'h8;
	localparam int          NCH             = 8;

	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [4:0]  CTRL_ADDR_RST   = 5'h00;
	localparam logic        CTRL_SHARED_RST = 1'b0;
	localparam int          CTRL_SHARED_BIT = 5;
	localparam int          ST_MAIN_LSB     = 0;
	localparam int          ST_MAIN_EXT     = 8;
	localparam int          ST_SUB_LSB      = 9;
	localparam int          ST_SUB_EXT      = 17;
	localparam int          ST_REMOTE       = 18;
	localparam int          ST_LOCKOUT      = 19;
	localparam int          ST_LISTEN       = 20;
	localparam int          ST_STARTSTOP    = 21;

	localparam logic [1:0]  MODE_EXTERNAL   = 2'h0;
	localparam logic [1:0]  MODE_MANUAL     = 2'h1;
	localparam logic [1:0]  MODE_AUTO       = 2'h2;

	localparam logic [6:0]  IB_LISTEN_BASE  = 7'h20;
	localparam logic [6:0]  IB_UNLISTEN     = 7'h3f;
	localparam logic [6:0]  IB_LOCKOUT      = 7'h11;
	localparam logic [6:0]  IB_GO_LOCAL     = 7'h01;

	localparam logic [3:0]  OP_MAIN_SEL     = 4'h1;
	localparam logic [3:0]  OP_SUB_SEL      = 4'h2;
	localparam logic [3:0]  OP_STEP         = 4'h3;
	localparam logic [3:0]  OP_RESET        = 4'h4;
	localparam logic [3:0]  OP_START_SET    = 4'h5;
	localparam logic [3:0]  OP_START_CLR    = 4'h6;
	localparam logic [3:0]  ARG_EXTENSION   = 4'h9;

	typedef enum logic [1:0] {CSSQ_AH_IDLE, CSSQ_AH_READY, CSSQ_AH_ACCEPT} cssq_ah_t;
endpackage

// *** verilog/cssq_dwell_timer.sv ***
module cssq_dwell_timer
	import cssq_pkg::*;
#(
	parameter int TICK_CYCLES = DWELL_BASE_CYC
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [3:0] dwell_sel,
	output logic            expire
);
	localparam int PW = $clog2(TICK_CYCLES + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [PW-1:0] pre;
		logic [8:0]    ticks;
		logic          expire;
	} cssq_tmr_t;

	cssq_tmr_t s;
	cssq_tmr_t next_s;
	logic [3:0] sel;
	logic [8:0] last;

	always_comb begin
		next_s = s;
		next_s.expire = 1'b0;
		sel = (dwell_sel > DWELL_SEL_MAX) ? DWELL_SEL_MAX : dwell_sel;
		last = (9'h001 << sel) - 9'h001;
		if (restart || !run) begin
			next_s.pre = '0;
			next_s.ticks = 9'h000;
		end else if (s.pre == PRE_LAST) begin
			next_s.pre = '0;
			if (s.ticks >= last) begin
				next_s.ticks = 9'h000;
				next_s.expire = 1'b1;
			end else begin
				next_s.ticks = s.ticks + 9'h001;
			end
		end else begin
			next_s.pre = s.pre + PW'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expire = s.expire;
endmodule

// *** verilog/cssq_sequencer.sv ***
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
module cssq_sequencer
	import cssq_pkg::*;
#(
	parameter int TICK_CYCLES = DWELL_BASE_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [1:0]  scan_mode,
	input  wire logic [3:0]  dwell_sel,
	input  wire logic [7:0]  pnl_inhibit,
	input  wire logic [7:0]  pnl_select,
	input  wire logic        pnl_reset,
	input  wire logic        pnl_step,
	input  wire logic        local_btn,
	input  wire logic        ext_step_n,
	input  wire logic        ext_reset_n,
	input  wire logic [7:0]  ib_dio_n,
	input  wire logic        ib_dav_n,
	input  wire logic        ib_atn_n,
	input  wire logic        ib_ren_n,
	output logic             ib_nrfd_oe,
	output logic             ib_ndac_oe,
	output logic [7:0]       main_led,
	output logic             main_ext_sel,
	output logic [7:0]       sub_led,
	output logic             sub_ext_sel,
	output logic             remote_led,
	output logic             link_step_oe,
	output logic             link_reset_oe,
	output logic             startstop_oe
);
	typedef struct packed {
		logic        ahb_wr;
		logic [7:0]  ahb_addr;
		logic [31:0] rdata;
		logic        ready;
		logic [4:0]  bus_addr;
		logic        shared;
		logic [2:0]  cur;
		logic        main_ext;
		logic [7:0]  main_led;
		logic [7:0]  sub_led;
		logic        sub_ext;
		logic        remote;
		logic        lockout;
		logic        listen;
		cssq_ah_t    ah;
		logic        nrfd_oe;
		logic        ndac_oe;
		logic        startstop;
		logic        step_out;
		logic        reset_out;
		logic        prev_prst;
		logic        prev_pstep;
		logic        prev_estep_n;
		logic        prev_erst_n;
	} cssq_state_t;

	cssq_state_t s;
	cssq_state_t next_s;

	logic       expire;
	logic       tmr_run;
	logic       tmr_restart;
	logic       panel_ok;
	logic       use_panel;
	logic       use_ext;
	logic       sel_any;
	logic [2:0] sel_ch;
	logic       do_reset;
	logic       do_step;
	logic       hold;
	logic [7:0] ib_byte;
	logic       ib_take;
	logic       bus_step;
	logic       bus_reset;
	logic       bus_main;
	logic       bus_sub;
	logic [3:0] op;
	logic [3:0] arg;
	logic [3:0] found_first;
	logic [3:0] found_next;
	logic [31:0] rd_val;

	// lowest non-inhibited channel; bit 3 flags that one exists
	function automatic logic [3:0] first_free(input logic [7:0] inh);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (!inh[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	// next non-inhibited channel above cur, wrapping past the top
	function automatic logic [3:0] next_free(input logic [2:0] cur, input logic [7:0] inh);
		logic [3:0] r;
		logic [2:0] c;
		r = 4'h0;
		for (int k = NCH - 1; k >= 1; k--) begin
			c = cur + 3'(k);
			if (!inh[c]) begin
				r = {1'b1, c};
			end
		end
		return r;
	endfunction

	cssq_dwell_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.run       (tmr_run),
		.restart   (tmr_restart),
		.dwell_sel (dwell_sel),
		.expire    (expire)
	);

	////////////////////////////////////////////////////////////////////////////////
	// combinational next state

	always_comb begin
		next_s = s;
		ib_byte = ~ib_dio_n;
		ib_take = 1'b0;
		bus_step = 1'b0;
		bus_reset = 1'b0;
		bus_main = 1'b0;
		bus_sub = 1'b0;
		op = ib_byte[7:4];
		arg = ib_byte[3:0];
		sel_ch = 3'h0;

		// ahb slave: zero wait states, read data latched at the address phase
		next_s.ready = 1'b1;
		next_s.ahb_wr = 1'b0;
		rd_val = 32'h0000_0000;
		if (haddr[7:0] == REG_CTRL) begin
			rd_val = {26'h0, s.shared, s.bus_addr};
		end else if (haddr[7:0] == REG_STATUS) begin
			rd_val = {10'h0, s.startstop, s.listen, s.lockout, s.remote, s.sub_ext,
				s.sub_led, s.main_ext, s.main_led};
		end
		if (hsel && htrans[1] && hready) begin
			next_s.ahb_wr = hwrite;
			next_s.ahb_addr = haddr[7:0];
			next_s.rdata = hwrite ? 32'h0000_0000 : rd_val;
		end
		if (s.ahb_wr && s.ahb_addr == REG_CTRL) begin
			next_s.bus_addr = hwdata[4:0];
			next_s.shared = hwdata[CTRL_SHARED_BIT];
		end

		// acceptor handshake; a byte is taken on the first cycle dav is low
		case (s.ah)
			CSSQ_AH_IDLE: begin
				next_s.nrfd_oe = 1'b0;
				next_s.ndac_oe = 1'b0;
				if (!ib_atn_n || s.listen) begin
					next_s.ndac_oe = 1'b1;
					next_s.ah = CSSQ_AH_READY;
				end
			end
			CSSQ_AH_READY: begin
				if (ib_atn_n && !s.listen) begin
					next_s.nrfd_oe = 1'b0;
					next_s.ndac_oe = 1'b0;
					next_s.ah = CSSQ_AH_IDLE;
				end else if (!ib_dav_n) begin
					ib_take = 1'b1;
					next_s.nrfd_oe = 1'b1;
					next_s.ndac_oe = 1'b0;
					next_s.ah = CSSQ_AH_ACCEPT;
				end
			end
			CSSQ_AH_ACCEPT: begin
				if (ib_dav_n) begin
					next_s.ndac_oe = 1'b1;
					next_s.nrfd_oe = 1'b0;
					next_s.ah = CSSQ_AH_READY;
				end
			end
			default: begin
				next_s.ah = CSSQ_AH_IDLE;
			end
		endcase

		// local clear first, so a bus listen with enable in the same cycle wins
		if (local_btn && s.remote && !s.lockout) begin
			next_s.remote = 1'b0;
		end

		// interface messages; anything not listed is ignored
		if (ib_take && !ib_atn_n) begin
			if (ib_byte[6:0] == (IB_LISTEN_BASE | {2'h0, s.bus_addr})) begin
				next_s.listen = 1'b1;
				if (!ib_ren_n) begin
					next_s.remote = 1'b1;
				end
			end else if (ib_byte[6:0] == IB_UNLISTEN) begin
				next_s.listen = 1'b0;
			end else if (ib_byte[6:0] == IB_LOCKOUT) begin
				next_s.lockout = 1'b1;
			end else if (ib_byte[6:0] == IB_GO_LOCAL && s.listen) begin
				next_s.remote = 1'b0;
			end
		end else if (ib_take && s.listen) begin
			bus_step = (op == OP_STEP);
			bus_reset = (op == OP_RESET);
			if (!s.shared) begin
				bus_main = (op == OP_MAIN_SEL) && arg >= 4'h1 && arg <= ARG_EXTENSION;
				bus_sub = (op == OP_SUB_SEL) && arg >= 4'h1 && arg <= ARG_EXTENSION;
				if (op == OP_START_SET) begin
					next_s.startstop = 1'b1;
				end else if (op == OP_START_CLR) begin
					next_s.startstop = 1'b0;
				end
			end
		end
		if (ib_ren_n) begin
			next_s.remote = 1'b0;
			next_s.lockout = 1'b0;
		end

		// subsidiary selection is touched by bus commands alone
		if (bus_sub) begin
			next_s.sub_ext = (arg == ARG_EXTENSION);
			if (arg != ARG_EXTENSION) begin
				next_s.sub_led = 8'h01 << (arg - 4'h1);
			end
		end

		// main scan; panel select, reset and step are dead while the bus holds remote, inhibit still applies
		panel_ok = !s.remote;
		use_panel = panel_ok && scan_mode != MODE_EXTERNAL;
		use_ext = scan_mode == MODE_EXTERNAL || scan_mode == MODE_MANUAL;
		sel_any = panel_ok && (pnl_select != 8'h00);
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pnl_select[i]) begin
				sel_ch = 3'(i);
			end
		end
		// open link inputs idle high, so only a falling edge acts
		do_reset = (use_panel && pnl_reset && !s.prev_prst)
			|| (use_ext && !ext_reset_n && s.prev_erst_n) || bus_reset;
		do_step = (use_panel && pnl_step && !s.prev_pstep)
			|| (use_ext && !ext_step_n && s.prev_estep_n) || bus_step;
		hold = sel_any || (use_panel && (pnl_reset || pnl_step));
		tmr_run = (scan_mode == MODE_AUTO) && !s.main_ext;
		tmr_restart = hold || do_reset || do_step || bus_main;
		found_first = first_free(pnl_inhibit);
		found_next = next_free(s.cur, pnl_inhibit);

		if (sel_any) begin
			next_s.cur = sel_ch;
			next_s.main_ext = 1'b0;
		end else if (bus_main) begin
			next_s.main_ext = (arg == ARG_EXTENSION);
			if (arg != ARG_EXTENSION) begin
				next_s.cur = 3'(arg - 4'h1);
			end
		end else if (do_reset) begin
			if (found_first[3]) begin
				next_s.cur = found_first[2:0];
				next_s.main_ext = 1'b0;
			end
		end else if (do_step || (expire && !hold)) begin
			if (found_next[3]) begin
				next_s.cur = found_next[2:0];
				next_s.main_ext = 1'b0;
			end
		end
		next_s.main_led = 8'h01 << next_s.cur;

		// cascade link forwards the incoming scan lines and the bus's own moves
		next_s.step_out = !ext_step_n || bus_step;
		next_s.reset_out = !ext_reset_n || bus_reset;
		next_s.prev_prst = pnl_reset;
		next_s.prev_pstep = pnl_step;
		next_s.prev_estep_n = ext_step_n;
		next_s.prev_erst_n = ext_reset_n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.ready <= 1'b1;
			s.bus_addr <= CTRL_ADDR_RST;
			s.shared <= CTRL_SHARED_RST;
			s.main_led <= 8'h01;
			s.sub_led <= 8'h01;
			s.ah <= CSSQ_AH_IDLE;
			s.prev_estep_n <= 1'b1;
			s.prev_erst_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register but hresp, which is tied low

	assign hreadyout = s.ready;
	assign hrdata = s.rdata;
	assign hresp = 1'b0;
	assign ib_nrfd_oe = s.nrfd_oe;
	assign ib_ndac_oe = s.ndac_oe;
	assign main_led = s.main_led;
	assign main_ext_sel = s.main_ext;
	assign sub_led = s.sub_led;
	assign sub_ext_sel = s.sub_ext;
	assign remote_led = s.remote;
	assign link_step_oe = s.step_out;
	assign link_reset_oe = s.reset_out;
	assign startstop_oe = s.startstop;
endmodule

// *** tb/cssq_sequencer_asserts.sv ***
module cssq_sequencer_asserts
	import cssq_pkg::*;
#(
	parameter int TICK_CYCLES = DWELL_BASE_CYC
) (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic [1:0] scan_mode,
	input wire logic [7:0] pnl_inhibit,
	input wire logic [7:0] pnl_select,
	input wire logic       pnl_reset,
	input wire logic       pnl_step,
	input wire logic       ext_step_n,
	input wire logic       ext_reset_n,
	input wire logic       ib_dav_n,
	input wire logic       ib_ren_n,
	input wire logic       ib_nrfd_oe,
	input wire logic       ib_ndac_oe,
	input wire logic [7:0] main_led,
	input wire logic       main_ext_sel,
	input wire logic       remote_led,
	input wire logic       link_step_oe,
	input wire logic       link_reset_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// nothing but panel or timer may move main in such a cycle
	sequence s_quiet;
		!remote_led && pnl_select == 8'h00 && ib_dav_n && ext_step_n && ext_reset_n;
	endsequence
	sequence s_man(logic b);
		scan_mode == MODE_MANUAL && pnl_inhibit == 8'h00 && !main_ext_sel && $rose(b);
	endsequence
	property p_step;
		s_quiet ##0 s_man(pnl_step) ##0 (!pnl_reset && main_led != 8'h80)
			|=> main_led == $past(main_led) << 1;
	endproperty
	a_step: assert property (p_step) else $error("step missed next channel");
	property p_rst;
		s_quiet ##0 s_man(pnl_reset) |=> main_led == 8'h01;
	endproperty
	a_rst: assert property (p_rst) else $error("reset missed first channel");
	property p_ext;
		s_quiet ##0 scan_mode == MODE_EXTERNAL |=> $stable(main_led);
	endproperty
	a_ext: assert property (p_ext) else $error("panel moved main in external");
	property p_sel;
		(!remote_led && $onehot(pnl_select))[*2] ##0 $stable(pnl_select) |-> main_led == pnl_select;
	endproperty
	a_sel: assert property (p_sel) else $error("held select not routed");
	property p_inh;
		$changed(main_led) && $past(pnl_select) == 8'h00 && $past(remote_led) == 1'h0
			|-> (main_led & $past(pnl_inhibit)) == 8'h00;
	endproperty
	a_inh: assert property (p_inh) else $error("scan landed on inhibited channel");
	property p_one;
		!main_ext_sel |-> $onehot(main_led);
	endproperty
	a_one: assert property (p_one) else $error("indicators not one-hot");
	property p_lstep;
		!ext_step_n |=> link_step_oe;
	endproperty
	a_lstep: assert property (p_lstep) else $error("step not passed on link");
	property p_lrst;
		!ext_reset_n |=> link_reset_oe;
	endproperty
	a_lrst: assert property (p_lrst) else $error("reset not passed on link");
	property p_rem;
		ib_ren_n |=> !remote_led;
	endproperty
	a_rem: assert property (p_rem) else $error("remote without enable");
	property p_ack;
		$rose(ib_nrfd_oe) |-> $past(ib_dav_n) == 1'h0 && !ib_ndac_oe;
	endproperty
	a_ack: assert property (p_ack) else $error("acceptor out of step");
	property p_dwell;
		scan_mode == MODE_AUTO && $fell(pnl_step) ##0 s_quiet |=> $stable(main_led)[*3];
	endproperty
	a_dwell: assert property (p_dwell) else $error("dwell cut short");
endmodule

bind cssq_sequencer cssq_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .scan_mode(scan_mode), .pnl_inhibit(pnl_inhibit),
	.pnl_select(pnl_select), .pnl_reset(pnl_reset), .pnl_step(pnl_step),
	.ext_step_n(ext_step_n), .ext_reset_n(ext_reset_n), .ib_dav_n(ib_dav_n),
	.ib_ren_n(ib_ren_n), .ib_nrfd_oe(ib_nrfd_oe), .ib_ndac_oe(ib_ndac_oe),
	.main_led(main_led), .main_ext_sel(main_ext_sel), .remote_led(remote_led),
	.link_step_oe(link_step_oe), .link_reset_oe(link_reset_oe));

// *** tb/cssq_ib_host.sv ***
module cssq_ib_host (
	input  wire logic  hclk,
	input  wire logic  nrfd_oe,
	input  wire logic  ndac_oe,
	output logic [7:0] dio_n,
	output logic       dav_n,
	output logic       atn_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int slow = 0;
	initial begin
		dio_n = 8'hff;
		dav_n = 1'h1;
		atn_n = 1'h1;
	end
	task automatic send(input logic atn, input logic [7:0] b);
		int i;
		i = 0;
		while (nrfd_oe !== 1'h0 && i < 20) begin
			@(posedge hclk);
			i++;
		end
		atn_n <= ~atn;
		dio_n <= ~b;
		@(posedge hclk);
		dav_n <= 1'h0;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while ((nrfd_oe !== 1'h1 || ndac_oe !== 1'h0) && i < 20);
		repeat (slow) @(posedge hclk);
		dav_n <= 1'h1;
		@(posedge hclk);
		// released data lines float back up to their idle-high pull-ups
		dio_n <= 8'hff;
		atn_n <= 1'h1;
		repeat (2) @(posedge hclk);
	endtask
endmodule

// *** tb/channel_scan_sequencer_tb_top.sv ***
module channel_scan_sequencer_tb_top
	import cssq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 4;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pnl_reset, pnl_step;
	logic        local_btn, ext_step_n, ext_reset_n, ib_dav_n, ib_atn_n, ib_ren_n;
	logic        ib_nrfd_oe, ib_ndac_oe, main_ext_sel, sub_ext_sel, remote_led;
	logic        link_step_oe, link_reset_oe, startstop_oe;
	logic [1:0]  htrans, scan_mode;
	logic [2:0]  hsize;
	logic [3:0]  dwell_sel;
	logic [7:0]  pnl_inhibit, pnl_select, ib_dio_n, main_led, sub_led;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          n_errors, check_count, c;
	cssq_sequencer #(.TICK_CYCLES(TICK)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scan_mode(scan_mode),
		.dwell_sel(dwell_sel), .pnl_inhibit(pnl_inhibit), .pnl_select(pnl_select),
		.pnl_reset(pnl_reset), .pnl_step(pnl_step), .local_btn(local_btn),
		.ext_step_n(ext_step_n), .ext_reset_n(ext_reset_n), .ib_dio_n(ib_dio_n),
		.ib_dav_n(ib_dav_n), .ib_atn_n(ib_atn_n), .ib_ren_n(ib_ren_n),
		.ib_nrfd_oe(ib_nrfd_oe), .ib_ndac_oe(ib_ndac_oe), .main_led(main_led),
		.main_ext_sel(main_ext_sel), .sub_led(sub_led), .sub_ext_sel(sub_ext_sel),
		.remote_led(remote_led), .link_step_oe(link_step_oe),
		.link_reset_oe(link_reset_oe), .startstop_oe(startstop_oe));
	cssq_ib_host host (.hclk(hclk), .nrfd_oe(ib_nrfd_oe), .ndac_oe(ib_ndac_oe),
		.dio_n(ib_dio_n), .dav_n(ib_dav_n), .atn_n(ib_atn_n));
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d of %0d checks", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		i = 0;
		do begin
			tick(1);
			i++;
		end while (hreadyout !== 1'h1 && i < 50);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		i = 0;
		do begin
			tick(1);
			i++;
		end while (hreadyout !== 1'h1 && i < 50);
		rd = hrdata;
	endtask
	// k = {reset, step, link reset, link step}
	task automatic ctl(input logic [7:0] sel, input logic [3:0] k);
		pnl_select <= sel;
		{pnl_reset, pnl_step} <= k[3:2];
		{ext_reset_n, ext_step_n} <= ~k[1:0];
		tick(2);
		pnl_select <= 8'h00;
		{pnl_reset, pnl_step} <= 2'h0;
		{ext_reset_n, ext_step_n} <= 2'h3;
		tick(2);
	endtask
	task automatic gap();
		logic [7:0] m;
		m = main_led;
		c = 0;
		while (main_led === m && c < 3000) begin
			tick(1);
			c++;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
	initial begin
		{hresetn, hsel, hwrite, pnl_reset, pnl_step, local_btn} = 6'h0;
		{ext_step_n, ext_reset_n, ib_ren_n} = 3'h7;
		{haddr, hwdata, htrans, hsize, dwell_sel} = {64'h0, 2'h0, 3'h2, 4'h0};
		{pnl_inhibit, pnl_select, scan_mode} = {16'h0, MODE_MANUAL};
		{n_errors, check_count} = {32'h0, 32'h0};
		tick(6);
		hresetn <= 1'h1;
		tick(1);
		check(main_led, 8'h01);
		ahb(1'h0, 32'(REG_STATUS), 32'h0);
		check(rd, (32'h1 << ST_MAIN_LSB) | (32'h1 << ST_SUB_LSB));
		ahb(1'h1, 32'h40, 32'h3f);
		ahb(1'h0, 32'h40, 32'h0);
		check(rd, 32'h0);
		ahb(1'h0, 32'(REG_CTRL), 32'h0);
		check(rd, 32'h0);
		ctl(8'h00, 4'h4);
		check(main_led, 8'h02);
		pnl_inhibit <= 8'h0a;
		ctl(8'h00, 4'h4);
		check(main_led, 8'h04);
		ctl(8'h00, 4'h1);
		check(main_led, 8'h10);
		pnl_inhibit <= 8'h03;
		ctl(8'h00, 4'h8);
		check(main_led, 8'h04);
		pnl_select <= 8'h40;
		tick(3);
		check(main_led, 8'h40);
		ctl(8'h00, 4'h0);
		ctl(8'h00, 4'h4);
		check(main_led, 8'h80);
		ctl(8'h00, 4'h4);
		check(main_led, 8'h04);
		scan_mode <= MODE_EXTERNAL;
		ctl(8'h00, 4'h4);
		check(main_led, 8'h04);
		ctl(8'h00, 4'h1);
		check(main_led, 8'h08);
		ctl(8'h00, 4'h2);
		check(main_led, 8'h04);
		scan_mode <= MODE_MANUAL;
		pnl_inhibit <= 8'hff;
		ctl(8'h00, 4'h4);
		check(main_led, 8'h04);
		pnl_inhibit <= 8'h00;
		ctl(8'h00, 4'h8);
		check(main_led, 8'h01);
		scan_mode <= MODE_AUTO;
		for (int n = 0; n < 9; n++) begin
			dwell_sel <= 4'(n);
			gap();
			gap();
			check(32'(c >= (TICK << n) && c <= (TICK << n) + 2), 32'h1);
		end
		dwell_sel <= 4'h3;
		gap();
		rd = 32'(main_led);
		ctl(8'h00, 4'h4);
		check(main_led, {rd[6:0], rd[7]});
		gap();
		check(32'(c >= 8 * TICK - 2 && c <= 8 * TICK + 2), 32'h1);
		scan_mode <= MODE_MANUAL;
		ib_ren_n <= 1'h0;
		host.send(1'h1, {1'h0, IB_LISTEN_BASE});
		check(remote_led, 1'h1);
		host.send(1'h0, {OP_MAIN_SEL, 4'h5});
		check(main_led, 8'h10);
		host.send(1'h0, {OP_SUB_SEL, 4'h3});
		check(sub_led, 8'h04);
		ctl(8'h01, 4'h4);
		check(sub_led, 8'h04);
		check(main_led, 8'h10);
		host.slow = 3;
		host.send(1'h0, {OP_SUB_SEL, ARG_EXTENSION});
		check(sub_ext_sel, 1'h1);
		host.send(1'h0, {OP_MAIN_SEL, ARG_EXTENSION});
		check(main_ext_sel, 1'h1);
		host.send(1'h0, {OP_START_SET, 4'h0});
		check(startstop_oe, 1'h1);
		host.send(1'h0, {OP_START_CLR, 4'h0});
		check(startstop_oe, 1'h0);
		host.send(1'h0, {OP_MAIN_SEL, 4'h3});
		check({main_ext_sel, main_led}, 9'h004);
		local_btn <= 1'h1;
		tick(3);
		local_btn <= 1'h0;
		tick(2);
		check(remote_led, 1'h0);
		host.send(1'h1, {1'h0, IB_LISTEN_BASE});
		host.send(1'h1, {1'h0, IB_LOCKOUT});
		local_btn <= 1'h1;
		tick(3);
		local_btn <= 1'h0;
		tick(2);
		check(remote_led, 1'h1);
		ahb(1'h1, 32'(REG_CTRL), 32'h1 << CTRL_SHARED_BIT);
		ahb(1'h0, 32'(REG_CTRL), 32'h0);
		check(rd, 32'h1 << CTRL_SHARED_BIT);
		check(hresp, 1'h0);
		host.send(1'h0, {OP_MAIN_SEL, 4'h6});
		check(main_led, 8'h04);
		host.send(1'h0, {OP_STEP, 4'h0});
		check(main_led, 8'h08);
		ahb(1'h0, 32'(REG_STATUS), 32'h0);
		check(rd, 32'h08 | (32'h04 << ST_SUB_LSB) | (32'hf << ST_SUB_EXT));
		host.send(1'h0, {OP_RESET, 4'h0});
		check(main_led, 8'h01);
		host.send(1'h1, {1'h0, IB_GO_LOCAL});
		check(remote_led, 1'h0);
		// once unaddressed, a data byte must not be accepted at all
		host.send(1'h1, {1'h0, IB_UNLISTEN});
		host.send(1'h0, {OP_STEP, 4'h0});
		check(main_led, 8'h01);
		stop_test();
	end
endmodule
